// *** bench/interrupt_priority_vectoring_test.sv ***
// Purpose: Self-checking bench for the interrupt priority and vectoring block
// Assumes: Grants are noted in a queue and matched in order by a monitor
// Notes: Any vector that was not noted counts as a mismatch
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module interrupt_priority_vectoring_test;
    import ipv_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic slow = 1'b0;
    logic sleep = 1'b0;
    logic wake0 = 1'b0;
    logic gie = 1'b0;
    logic rcs = 1'b0;
    logic reti = 1'b0;
    logic acc = 1'b0;
    logic [1:0] trig = 2'h0;
    logic [2:0] eset = 3'h0;
    logic [2:0] eread = 3'h0;
    logic [7:0] ebits = 8'h00;
    logic [7:0] b = 8'h00;
    logic [11:0] req = 12'h000;
    logic [11:0] en = 12'h000;
    logic [11:0] hprio = 12'h000;
    logic [15:0] exp_vec[$];
    logic [15:0] pc_stack[$];
    logic [15:0] pc_prev = 16'h0000;
    logic [15:0] ev;
    logic [15:0] ep;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    integer seed = 32'h5d52a62d;
    int ord[12] = '{0, 3, 1, 2, 4, 5, 6, 7, 8, 9, 10, 11};
    logic [15:0] vec_of[12] = '{VEC_SUPPLY, VEC_RTC, VEC_ENERGY, VEC_WDOG, VEC_TEMP,
        VEC_EXT0, VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_SERIAL, VEC_UART, VEC_TMR2};
    logic insn_done, vector_load, pc_return_valid, ext0_request_flag, ext1_request_flag;
    logic [15:0] pc_current, vector_addr, pc_push, pc_return;
    logic [7:0] es_high, es_mid, es_low;
    logic [1:0] active_level;

    always #2.5 mclk = ~mclk;

    ipv_core_model i_ipv_core_model (.mclk(mclk), .rst_n(rst_n), .slow(slow),
        .insn_done(insn_done), .pc_current(pc_current));

    // Pins are active low, so a request on an external source pulls its pin down
    ipv_ctrl i_ipv_ctrl (.mclk(mclk), .rst_n(rst_n), .sleep_mode(sleep),
        .ext_pin_0(~req[5]), .ext_pin_1(~req[7]), .ext0_trigger_type(trig[0]),
        .ext1_trigger_type(trig[1]), .wake_ext0(wake0), .wake_ext1(1'b0),
        .supply_monitor_irq(req[0]), .rtc_interval_irq(req[1]), .energy_dsp_irq(req[2]),
        .watchdog_irq(req[3]), .temperature_adc_irq(req[4]), .timer0_overflow_flag(req[6]),
        .timer1_overflow_flag(req[8]), .timer2_overflow_flag(req[11]),
        .timer2_external_flag(1'b0), .serial_port_irq(req[9]), .uart_receive_flag(req[10]),
        .uart_transmit_flag(1'b0), .ext0_flag_clear(1'b0), .ext1_flag_clear(1'b0),
        .src_enable(en), .global_int_enable(gie), .src_high_prio(hprio),
        .read_clear_select(rcs), .energy_status_set(eset), .energy_set_bits(ebits),
        .energy_status_read(eread), .insn_done(insn_done), .reti_exec(reti),
        .ie_ip_access(acc), .pc_current(pc_current), .ext0_request_flag(ext0_request_flag),
        .ext1_request_flag(ext1_request_flag), .energy_status_high(es_high),
        .energy_status_mid(es_mid),
        .energy_status_low(es_low), .vector_load(vector_load), .vector_addr(vector_addr),
        .pc_push(pc_push), .pc_return(pc_return), .pc_return_valid(pc_return_valid),
        .active_level(active_level));

    // Monitor: match each grant with the oldest note, and each return with its push
    always @(posedge mclk) begin
        if (vector_load === 1'b1) begin
            if (exp_vec.size() == 0) begin
                fails++;
                $display("mismatch at %0t: unexpected vector %h", $time, vector_addr);
            end else begin
                ev = exp_vec.pop_front();
                `CHK(vector_addr, ev)
                `CHK(pc_push, pc_prev)
                pc_stack.push_back(pc_prev);
            end
        end
        if (pc_return_valid === 1'b1 && pc_stack.size() > 0) begin
            ep = pc_stack.pop_back();
            `CHK(pc_return, ep)
        end
        pc_prev = pc_current;
    end

    // A hang is cut off well beyond the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Wait on the falling edge until only n notes remain
    task automatic wait_q(input int n);
        int k;
        k = 0;
        while (exp_vec.size() != n && k < 400) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 400) begin
            fails++;
            $display("mismatch at %0t: grant missing", $time);
        end
    endtask

    // Leave the running service routine after a short body
    task automatic fin();
        repeat (2) @(posedge mclk);
        reti <= 1'b1;
        @(posedge mclk);
        reti <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        // All twelve enabled, none set high: supply, then watchdog, then poll order
        en <= 12'hfff;
        gie <= 1'b1;
        for (int k = 0; k < 12; k++) exp_vec.push_back(vec_of[ord[k]]);
        req <= 12'hfff;
        @(posedge mclk);
        req <= 12'hded;
        for (int k = 0; k < 12; k++) begin
            wait_q(11 - k);
            @(posedge mclk) req[ord[k]] <= 1'b0;
            fin();
        end
        // Low-level external re-enters while the pin stays low
        en <= 12'h020;
        exp_vec.push_back(VEC_EXT0);
        exp_vec.push_back(VEC_EXT0);
        req[5] <= 1'b1;
        wait_q(1);
        `CHK(ext0_request_flag, 1'b1)
        fin();
        wait_q(0);
        @(posedge mclk) req[5] <= 1'b0;
        fin();
        // Edge mode clears the flag on entry, so a held pin does not re-enter
        trig <= 2'h1;
        exp_vec.push_back(VEC_EXT0);
        @(posedge mclk) req[5] <= 1'b1;
        wait_q(0);
        `CHK(ext0_request_flag, 1'b0)
        fin();
        repeat (10) @(posedge mclk);
        req[5] <= 1'b0;
        // Sleep freezes the flag against pin events, a wake-up still sets it
        en <= 12'h000;
        sleep <= 1'b1;
        repeat (3) @(posedge mclk);
        req[5] <= 1'b1;
        repeat (4) @(negedge mclk);
        `CHK(ext0_request_flag, 1'b0)
        @(posedge mclk) req[5] <= 1'b0;
        wake0 <= 1'b1;
        @(posedge mclk) wake0 <= 1'b0;
        repeat (3) @(negedge mclk);
        `CHK(ext0_request_flag, 1'b1)
        @(posedge mclk) sleep <= 1'b0;
        exp_vec.push_back(VEC_EXT0);
        en <= 12'h020;
        wait_q(0);
        fin();
        // Global disable holds the timer back but not the watchdog; serial stays latched
        slow <= 1'b1;
        trig <= 2'h0;
        gie <= 1'b0;
        en <= 12'hdff;
        req[6] <= 1'b1;
        req[9] <= 1'b1;
        @(posedge mclk) req[9] <= 1'b0;
        repeat (30) @(posedge mclk);
        exp_vec.push_back(VEC_WDOG);
        req[3] <= 1'b1;
        wait_q(0);
        @(posedge mclk) req[3] <= 1'b0;
        fin();
        exp_vec.push_back(VEC_TMR0);
        exp_vec.push_back(VEC_SERIAL);
        en <= 12'hfff;
        gie <= 1'b1;
        acc <= 1'b1;
        @(posedge mclk) acc <= 1'b0;
        wait_q(1);
        @(posedge mclk) req[6] <= 1'b0;
        fin();
        wait_q(0);
        fin();
        // A high-level timer preempts a running low-level one
        hprio <= 12'h100;
        exp_vec.push_back(VEC_TMR0);
        req[6] <= 1'b1;
        wait_q(0);
        exp_vec.push_back(VEC_TMR1);
        @(posedge mclk) req[8] <= 1'b1;
        wait_q(0);
        `CHK(active_level, 2'h2)
        @(posedge mclk) req <= 12'h000;
        fin();
        @(negedge mclk);
        `CHK(active_level, 2'h1)
        fin();
        // Auto-clear empties only the byte that is read
        b = 8'($random(seed)) | 8'h01;
        rcs <= 1'b1;
        eset <= 3'h7;
        ebits <= b;
        @(posedge mclk) eset <= 3'h0;
        eread <= 3'h4;
        @(posedge mclk) eread <= 3'h0;
        @(negedge mclk);
        `CHK(es_high, 8'h00)
        `CHK(es_mid, b)
        `CHK(es_low, b)
        @(posedge mclk) eread <= 3'h3;
        @(posedge mclk) eread <= 3'h0;
        @(negedge mclk);
        `CHK({es_mid, es_low}, 16'h0000)
        @(posedge mclk) rcs <= 1'b0;
        eset <= 3'h7;
        @(posedge mclk) eset <= 3'h0;
        eread <= 3'h7;
        @(posedge mclk) eread <= 3'h0;
        @(negedge mclk);
        `CHK({es_high, es_low}, {b, b})
        repeat (10) @(posedge mclk);
        `CHK(exp_vec.size(), 0)
        `CHK(ext1_request_flag, 1'b0)
        print_verdict();
    end
endmodule

// *** bench/ipv_core_model.sv ***
// Purpose: Behavioural core pacing instruction boundaries and the PC
// Assumes: One instruction a cycle when fast, one in three when slow
// Notes: PC simply counts; jumps to vectors are not modelled
`timescale 1ns/100ps
module ipv_core_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic slow,
    output logic insn_done,
    output logic [15:0] pc_current
);
    logic [1:0] gap_reg;
    // Boundary is high every cycle when fast, a one-cycle pulse every third cycle when slow
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 2'h0;
            insn_done <= 1'b0;
            pc_current <= 16'h0100;
        end else begin
            gap_reg <= (slow && gap_reg != 2'h2) ? gap_reg + 2'h1 : 2'h0;
            insn_done <= !slow || gap_reg == 2'h2;
            if (insn_done) begin
                pc_current <= pc_current + 16'h0001;
            end
        end
    end
endmodule

// *** verilog/ipv_ctrl.sv ***
// Purpose: Latch, arbitrate and vector twelve interrupt sources to the core
// Assumes: Core gives one-cycle strobes for instruction end, return and register access
// Notes: PC stack holds DEPTH entries; each push saves the PC and the interrupted level
`timescale 1ns/100ps
// What this block does
// R1: Equal-level requests granted in fixed poll order
// R2: Supply monitor alone in the top level
// R3: Temperature request has no visible flag
// R4: Auto-clear zeroes each energy byte after read
// R5: Reading high energy byte clears only it
// R6: Wake-up event makes external request pending
// R7: Enabled external wake request loads its vector
// R8: Sleep blocks pin changes to external flags
// R9: RTC, temperature, serial latched until service entry
// R10: Clearing RTC flags keeps RTC request pending
// R11: Clearing serial status keeps serial request pending
// R12: Latched requests wait while disabled, then serviced
// R13: Merged vectors never auto-clear on entry
// R14: External flag auto-clears only when edge triggered
// R15: Low-level external keeps re-entering while low
// R16: Grant pushes PC, then loads vector
// R17: Return pops saved PC to resume
// R18: Vectors for externals, timers, UART
// R19: Vectors for temperature, serial, supply, energy, RTC, watchdog
// R20: Watchdog high priority, global enable ignored
// R21: One instruction after return or register access
// R22: Enables gate grants; only higher levels preempt
module ipv_ctrl
    import ipv_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sleep_mode,
    input wire logic ext_pin_0,
    input wire logic ext_pin_1,
    input wire logic ext0_trigger_type,
    input wire logic ext1_trigger_type,
    input wire logic wake_ext0,
    input wire logic wake_ext1,
    input wire logic supply_monitor_irq,
    input wire logic rtc_interval_irq,
    input wire logic energy_dsp_irq,
    input wire logic watchdog_irq,
    input wire logic temperature_adc_irq,
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire logic serial_port_irq,
    input wire logic uart_receive_flag,
    input wire logic uart_transmit_flag,
    input wire logic ext0_flag_clear,
    input wire logic ext1_flag_clear,
    input wire logic [ipv_pkg::NSRC-1:0] src_enable,
    input wire logic global_int_enable,
    input wire logic [ipv_pkg::NSRC-1:0] src_high_prio,
    input wire logic read_clear_select,
    input wire logic [2:0] energy_status_set,
    input wire logic [7:0] energy_set_bits,
    input wire logic [2:0] energy_status_read,
    input wire logic insn_done,
    input wire logic reti_exec,
    input wire logic ie_ip_access,
    input wire logic [15:0] pc_current,
    output logic ext0_request_flag,
    output logic ext1_request_flag,
    output logic [7:0] energy_status_high,
    output logic [7:0] energy_status_mid,
    output logic [7:0] energy_status_low,
    output logic vector_load,
    output logic [15:0] vector_addr,
    output logic [15:0] pc_push,
    output logic [15:0] pc_return,
    output logic pc_return_valid,
    output logic [1:0] active_level
);
    import ipv_pkg::*;

    logic ext0_reg, ext1_reg, ext0_next, ext1_next;
    logic [2:0] latch_reg, latch_next;
    logic [7:0] est_reg [3];
    logic [7:0] est_next [3];
    logic hold_reg;
    logic [1:0] act_reg, act_next;
    logic [15:0] stk_reg [DEPTH];
    logic [1:0] lvl_stk_reg [DEPTH];
    logic [1:0] sp_reg;
    logic [15:0] vec_reg, push_reg, ret_reg;
    logic load_reg, retv_reg;

    // Vector table lookup by poll index
    function automatic logic [15:0] vec_of(input logic [3:0] i);
        case (i)
            4'h0: vec_of = VEC_SUPPLY; // see R19
            4'h1: vec_of = VEC_RTC;
            4'h2: vec_of = VEC_ENERGY;
            4'h3: vec_of = VEC_WDOG;
            4'h4: vec_of = VEC_TEMP;
            4'h5: vec_of = VEC_EXT0; // see R18
            4'h6: vec_of = VEC_TMR0;
            4'h7: vec_of = VEC_EXT1;
            4'h8: vec_of = VEC_TMR1;
            4'h9: vec_of = VEC_SERIAL;
            4'ha: vec_of = VEC_UART;
            4'hb: vec_of = VEC_TMR2;
            default: vec_of = PC_RST;
        endcase
    endfunction

    // Pin level or edge per trigger type; sleep masks pin events but not wake-ups
    wire ext0_fall = ext0_trigger_type ? 1'b0 : !ext_pin_0;
    wire ext1_fall = ext1_trigger_type ? 1'b0 : !ext_pin_1;
    logic pin0_d, pin1_d;
    wire ext0_evt = ext0_trigger_type ? (pin0_d & !ext_pin_0) : ext0_fall;
    wire ext1_evt = ext1_trigger_type ? (pin1_d & !ext_pin_1) : ext1_fall;
    wire ext0_set = (!sleep_mode & ext0_evt) | wake_ext0; // see R8, R6
    wire ext1_set = (!sleep_mode & ext1_evt) | wake_ext1; // see R8, R6

    // Request vector in poll order; latched sources use internal copies
    wire [NSRC-1:0] req_o;
    assign req_o[SRC_SUPPLY] = supply_monitor_irq;
    assign req_o[SRC_RTC] = latch_reg[0];
    assign req_o[SRC_ENERGY] = energy_dsp_irq;
    assign req_o[SRC_WDOG] = watchdog_irq;
    assign req_o[SRC_TEMP] = latch_reg[1]; // see R3
    assign req_o[SRC_EXT0] = ext0_reg;
    assign req_o[SRC_TMR0] = timer0_overflow_flag;
    assign req_o[SRC_EXT1] = ext1_reg;
    assign req_o[SRC_TMR1] = timer1_overflow_flag;
    assign req_o[SRC_SERIAL] = latch_reg[2];
    assign req_o[SRC_UART] = uart_receive_flag | uart_transmit_flag;
    assign req_o[SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;

    // Enable gating; watchdog bypasses the global enable
    wire [NSRC-1:0] wd_bit = NSRC'(1) << SRC_WDOG;
    wire [NSRC-1:0] armed = req_o & src_enable & ({NSRC{global_int_enable}} | wd_bit); // see R22, R20
    // Level split: supply alone on top, watchdog forced high
    wire [NSRC-1:0] sup_bit = NSRC'(1) << SRC_SUPPLY;
    wire [NSRC-1:0] top_req = armed & sup_bit; // see R2
    wire [NSRC-1:0] hi_req = armed & ~sup_bit & (src_high_prio | wd_bit); // see R20
    wire [NSRC-1:0] lo_req = armed & ~sup_bit & ~(src_high_prio | wd_bit);

    logic top_f, hi_f, lo_f;
    logic [3:0] hi_i, lo_i;
    ipv_pick u_hi (.req(hi_req), .found(hi_f), .idx(hi_i)); // see R1
    ipv_pick u_lo (.req(lo_req), .found(lo_f), .idx(lo_i));
    assign top_f = |top_req;

    // Only a strictly higher level than the running one may preempt
    wire take_top = top_f & (act_reg != LVL_TOP);
    wire take_hi = !take_top & hi_f & (act_reg < LVL_HIGH);
    wire take_lo = !take_top & !take_hi & lo_f & (act_reg == LVL_NONE); // see R22
    // Grant only at an instruction boundary, not right after return or access
    wire grant = insn_done & !hold_reg & !reti_exec & !ie_ip_access
                 & (take_top | take_hi | take_lo); // see R21
    wire [3:0] gidx = take_top ? 4'(SRC_SUPPLY) : (take_hi ? hi_i : lo_i);
    wire [1:0] glvl = take_top ? LVL_TOP : (take_hi ? LVL_HIGH : LVL_LOW);
    wire [NSRC-1:0] gone = grant ? (NSRC'(1) << gidx) : '0;
    wire pop = reti_exec & (sp_reg != 2'd0);

    // Flag and latch updates; set beats service clear
    always_comb begin
        // Edge-mode flags clear on entry or by software; level mode follows the pin
        ext0_next = ext0_trigger_type ? ((ext0_reg & !gone[SRC_EXT0] & !ext0_flag_clear)
                    | ext0_set) : (sleep_mode ? (ext0_reg | wake_ext0) : ext0_set); // see R14, R15
        ext1_next = ext1_trigger_type ? ((ext1_reg & !gone[SRC_EXT1] & !ext1_flag_clear)
                    | ext1_set) : (sleep_mode ? (ext1_reg | wake_ext1) : ext1_set); // see R14, R15
        // Only service entry removes these; software flag clears never reach here
        latch_next[0] = (latch_reg[0] & !gone[SRC_RTC]) | rtc_interval_irq; // see R9, R10, R12
        latch_next[1] = (latch_reg[1] & !gone[SRC_TEMP]) | temperature_adc_irq; // see R9
        latch_next[2] = (latch_reg[2] & !gone[SRC_SERIAL]) | serial_port_irq; // see R9, R11, R12
        for (int b = 0; b < 3; b++) begin
            est_next[b] = ((read_clear_select & energy_status_read[b]) ? BYTE_RST : est_reg[b])
                          | (energy_status_set[b] ? energy_set_bits : BYTE_RST); // see R4, R5
        end
        act_next = act_reg;
        if (grant)
            act_next = glvl;
        else if (pop)
            act_next = lvl_stk_reg[sp_reg[0] ^ 1'b1]; // see R22
    end

    // Previous pin levels for edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin0_d <= 1'b1;
            pin1_d <= 1'b1;
        end else begin
            pin0_d <= ext_pin_0;
            pin1_d <= ext_pin_1;
        end
    end

    // Request state; merged sources are never cleared here
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext0_reg <= 1'b0;
            ext1_reg <= 1'b0;
            latch_reg <= 3'b000;
            est_reg[0] <= BYTE_RST;
            est_reg[1] <= BYTE_RST;
            est_reg[2] <= BYTE_RST;
        end else begin
            ext0_reg <= ext0_next;
            ext1_reg <= ext1_next;
            latch_reg <= latch_next; // see R13
            est_reg <= est_next;
        end
    end

    // Hold off one instruction after return or enable/priority access
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            hold_reg <= 1'b0;
        else if (reti_exec | ie_ip_access)
            hold_reg <= 1'b1; // see R21
        else if (insn_done)
            hold_reg <= 1'b0;
    end

    // PC and level stacks; a return resumes the level it interrupted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= 2'd0;
            stk_reg[0] <= PC_RST;
            stk_reg[1] <= PC_RST;
            lvl_stk_reg[0] <= LVL_NONE;
            lvl_stk_reg[1] <= LVL_NONE;
            act_reg <= LVL_NONE;
            vec_reg <= PC_RST;
            push_reg <= PC_RST;
            ret_reg <= PC_RST;
            load_reg <= 1'b0;
            retv_reg <= 1'b0;
        end else begin
            act_reg <= act_next;
            load_reg <= grant;
            retv_reg <= pop;
            if (grant) begin
                stk_reg[sp_reg[0]] <= pc_current; // see R16
                lvl_stk_reg[sp_reg[0]] <= act_reg;
                sp_reg <= sp_reg + 2'd1;
                push_reg <= pc_current;
                vec_reg <= vec_of(gidx); // see R7
            end else if (pop) begin
                ret_reg <= stk_reg[sp_reg[0] ^ 1'b1]; // see R17
                sp_reg <= sp_reg - 2'd1;
            end
        end
    end

    assign ext0_request_flag = ext0_reg;
    assign ext1_request_flag = ext1_reg;
    assign energy_status_high = est_reg[2];
    assign energy_status_mid = est_reg[1];
    assign energy_status_low = est_reg[0];
    assign vector_load = load_reg;
    assign vector_addr = vec_reg;
    assign pc_push = push_reg;
    assign pc_return = ret_reg;
    assign pc_return_valid = retv_reg;
    assign active_level = act_reg;

    // Checks
    property p_vec_follows;
        @(posedge mclk) disable iff (!rst_n)
        grant |=> vector_load && vector_addr == vec_of($past(gidx));
    endproperty
    a_vec_follows: assert property (p_vec_follows) else $error("vector wrong"); // see R16
    property p_no_grant_after_reti;
        @(posedge mclk) disable iff (!rst_n)
        reti_exec |=> !grant;
    endproperty
    a_no_grant_after_reti: assert property (p_no_grant_after_reti) else $error("early grant"); // see R21
    property p_wd_ignores_ea;
        @(posedge mclk) disable iff (!rst_n)
        !global_int_enable && grant |-> gidx == 4'(SRC_WDOG);
    endproperty
    a_wd_ignores_ea: assert property (p_wd_ignores_ea) else $error("masked grant"); // see R20
    property p_rtc_held;
        @(posedge mclk) disable iff (!rst_n)
        latch_reg[0] && !gone[SRC_RTC] |=> latch_reg[0];
    endproperty
    a_rtc_held: assert property (p_rtc_held) else $error("rtc lost"); // see R10
    property p_serial_held;
        @(posedge mclk) disable iff (!rst_n)
        latch_reg[2] && !gone[SRC_SERIAL] |=> latch_reg[2];
    endproperty
    a_serial_held: assert property (p_serial_held) else $error("serial lost"); // see R11
    property p_hi_clear;
        @(posedge mclk) disable iff (!rst_n)
        read_clear_select && energy_status_read == 3'b100 && energy_status_set[2:1] == 2'b00
        |=> energy_status_high == 8'h00 && $stable(energy_status_mid);
    endproperty
    a_hi_clear: assert property (p_hi_clear) else $error("byte clear"); // see R5
    property p_sleep_freeze;
        @(posedge mclk) disable iff (!rst_n)
        sleep_mode && !wake_ext0 && ext0_reg && !gone[SRC_EXT0] && !ext0_flag_clear
        |=> ext0_reg;
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("flag moved"); // see R8
    property p_sleep_no_set;
        @(posedge mclk) disable iff (!rst_n)
        sleep_mode && !wake_ext0 && !ext0_reg |=> !ext0_reg;
    endproperty
    a_sleep_no_set: assert property (p_sleep_no_set) else $error("pin set flag"); // see R8
    property p_order;
        @(posedge mclk) disable iff (!rst_n)
        grant && take_hi |-> (hi_req & ((NSRC'(1) << gidx) - NSRC'(1))) == '0;
    endproperty
    a_order: assert property (p_order) else $error("poll order"); // see R1
endmodule

// *** verilog/ipv_pick.sv ***
// Purpose: Fixed-order pick of the first asserted request in a mask
// Assumes: Bit 0 is polled first
// Notes: Purely combinational
`timescale 1ns/100ps
module ipv_pick
    import ipv_pkg::*;
(
    input wire logic [ipv_pkg::NSRC-1:0] req,
    output logic found,
    output logic [3:0] idx
);
    // Scan from the last bit down so the lowest index wins
    always_comb begin
        found = 1'b0;
        idx = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = 4'(i);
            end
        end
    end
endmodule

// *** verilog/ipv_pkg.sv ***
// Purpose: Shared constants for the interrupt priority and vectoring block
// Assumes: Twelve sources, index 0 is polled first within a level
// Notes: Vector addresses are 16-bit program counter values
package ipv_pkg;
    localparam int NSRC = 12;
    // Poll order within a level
    localparam int SRC_SUPPLY = 0;
    localparam int SRC_RTC = 1;
    localparam int SRC_ENERGY = 2;
    localparam int SRC_WDOG = 3;
    localparam int SRC_TEMP = 4;
    localparam int SRC_EXT0 = 5;
    localparam int SRC_TMR0 = 6;
    localparam int SRC_EXT1 = 7;
    localparam int SRC_TMR1 = 8;
    localparam int SRC_SERIAL = 9;
    localparam int SRC_UART = 10;
    localparam int SRC_TMR2 = 11;
    // Vector addresses
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001b;
    localparam logic [15:0] VEC_UART = 16'h0023;
    localparam logic [15:0] VEC_TMR2 = 16'h002b;
    localparam logic [15:0] VEC_TEMP = 16'h0033;
    localparam logic [15:0] VEC_SERIAL = 16'h003b;
    localparam logic [15:0] VEC_SUPPLY = 16'h0043;
    localparam logic [15:0] VEC_ENERGY = 16'h004b;
    localparam logic [15:0] VEC_RTC = 16'h0053;
    localparam logic [15:0] VEC_WDOG = 16'h005b;
    // Reset values
    localparam logic [NSRC-1:0] PEND_RST = 12'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam int DEPTH = 2;
    typedef enum logic [1:0] {
        LVL_NONE = 2'b00,
        LVL_LOW = 2'b01,
        LVL_HIGH = 2'b10,
        LVL_TOP = 2'b11
    } ipv_level_t;
endpackage
